/* logic/rpc_pkg.sv */
// Package: register map, field layout and timing for the regulator control
package rpc_pkg;

  localparam int NREG = 4;            // 0,1 switchers; 2,3 linear regulators
  localparam int NSW  = 2;

  // Register byte offsets on the 32-bit bus
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_DELAY  = 5'h04;
  localparam logic [4:0] OFF_SW0    = 5'h08;
  localparam logic [4:0] OFF_SW1    = 5'h0C;
  localparam logic [4:0] OFF_LIN    = 5'h10;
  localparam logic [4:0] OFF_MASK   = 5'h14;
  localparam logic [4:0] OFF_FLAGS  = 5'h18;
  localparam logic [4:0] OFF_STATUS = 5'h1C;

  // Control word fields
  localparam int CTRL_ON     = 0;     // [3:0]  on bits
  localparam int CTRL_FOLLOW = 4;     // [7:4]  pin follow bits
  localparam int CTRL_PLL    = 8;     // external sync enable
  localparam int CTRL_PD     = 9;     // pin pulldown on
  localparam int CTRL_SWWIN  = 10;    // switcher window select
  localparam int CTRL_LNWIN  = 11;    // linear window select
  localparam int CTRL_FFF    = 12;    // [13:12] fixed frequency force
  localparam int CTRL_SMASK  = 14;    // sync event mask
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMSK = 32'h0000_7FFF;

  // Per regulator delay byte: start wait [3:0], stop wait [7:4]
  localparam int DLY_STRIDE = 8;
  localparam int DLY_STOP   = 4;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;

  // Switcher word: target code [7:0], ramp rate [10:8]
  localparam int SW_RATE = 8;
  localparam logic [31:0] SW_RST   = 32'h0000_0000;
  localparam logic [31:0] SW_WMSK  = 32'h0000_07FF;
  // Linear word: lin0 code [4:0], lin1 code [12:8]
  localparam int LIN_STRIDE = 8;
  localparam logic [31:0] LIN_RST  = 32'h0000_0000;
  localparam logic [31:0] LIN_WMSK = 32'h0000_1F1F;
  // Mask word: rise masks [3:0], fall masks [7:4]
  localparam int MASK_FALL = 4;
  localparam logic [31:0] MASK_RST  = 32'h0000_0000;
  localparam logic [31:0] MASK_WMSK = 32'h0000_00FF;
  // Flag word: short [3:0], good [7:4], sync [8]
  localparam int FLG_GOOD = 4;
  localparam int FLG_SYNC = 8;
  localparam int FLG_W    = 9;

  // Timing, clock 200 MHz
  localparam int CLK_MHZ       = 200;
  localparam int LOAD_WAIT_US  = 1200;   // host quiet time after reset
  localparam int SHORT_MS      = 1;      // short and overload debounce
  localparam int DELAY_LSB_MS  = 1;      // start and stop wait step
  localparam int LIN_SETTLE_US = 100;    // linear good settle after change
  localparam int RAMP_STEP_NS  = 500;    // fastest ramp step period
  localparam int LOAD_CYC_DEF  = LOAD_WAIT_US * CLK_MHZ;
  localparam int SHORT_CYC_DEF = SHORT_MS * 1000 * CLK_MHZ;
  localparam int DLY_CYC_DEF   = DELAY_LSB_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_CYC_DEF = LIN_SETTLE_US * CLK_MHZ;
  localparam int RAMP_CYC_DEF  = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_STBY = 3'b010,
    ST_ACTV = 3'b100
  } rpc_state_t;

  // Analog comparator results, asynchronous to mclk
  typedef struct packed {
    logic [NREG-1:0] belowShort;   // output under short threshold
    logic [NREG-1:0] underOk;      // above undervoltage threshold
    logic [NREG-1:0] overHigh;     // above overvoltage threshold
    logic            extClkOk;     // external clock valid
    logic            enablePin;    // enable pin level
  } rpc_ana_t;

  // Drive toward the analog regulators
  typedef struct packed {
    logic [NREG-1:0] regOn;
    logic [NSW-1:0]  softStart;
    logic [NSW-1:0]  fixedFreq;
    logic [7:0]      swCode1;
    logic [7:0]      swCode0;
    logic [4:0]      linCode1;
    logic [4:0]      linCode0;
    logic            clkSelExt;
    logic            pinPulldownOn;
  } rpc_drive_t;

endpackage : rpc_pkg

/* logic/rpc_regulator_ctrl.sv */
// Regulator enable, sequencing, protection and power-good control
//
// Operation
// - Sync enabled: detector runs, external clock auto-selected
// - Sync event only when enabled, on clock change
// - After load, bus opens and standby entered
// - Enable requests accepted in standby or active
// - On bit clear disables; pin ignored unless follow
// - On and follow set: output tracks pin
// - Start/stop waits after pin rise/fall edges
// - Waits only for pin edges, not writes
// - Soft-start until 0.35 V, then ramp rate
// - Switcher short below 0.35 V 1 ms trips
// - Linear short below 0.3 V 1 ms trips
// - Good rise sets good flag unless masked
// - Good fall sets good flag, own mask
// - Live good status reflects validity, held while blanked
// - Window select: undervoltage only or both
// - Pin pulldown switched by configuration bit
// - Switcher target write ramps at rate field
// - Fixed frequency forced while ramping
// - Linear good blanked 100 us after change
// - Flags cleared by writing one
// - Interrupt low while unmasked flag pending
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module rpc_regulator_ctrl
  import rpc_pkg::*;
#(
  parameter int LOAD_CYC   = LOAD_CYC_DEF,
  parameter int SHORT_CYC  = SHORT_CYC_DEF,
  parameter int DLY_CYC    = DLY_CYC_DEF,
  parameter int SETTLE_CYC = SETTLE_CYC_DEF,
  parameter int RAMP_CYC   = RAMP_CYC_DEF
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  rpc_ana_t         anaIn,
  output rpc_drive_t       drive,
  output logic             irq_out_low
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int SYW = $bits(rpc_ana_t);
  logic [SYW-1:0] syncA_q;
  logic [SYW-1:0] syncB_q;
  rpc_ana_t       ana;
  logic           pinLast_q;
  logic           pinRise;
  logic           pinFall;
  logic           extLast_q;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      syncA_q <= '0;
      syncB_q <= '0;
    end
    else
    begin
      syncA_q <= anaIn;
      syncB_q <= syncA_q;
    end

  assign ana = rpc_ana_t'(syncB_q);

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      pinLast_q <= 1'b0;
      extLast_q <= 1'b0;
    end
    else
    begin
      pinLast_q <= ana.enablePin;
      extLast_q <= ana.extClkOk;
    end

  assign pinRise = ana.enablePin & ~pinLast_q;
  assign pinFall = ~ana.enablePin & pinLast_q;

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus slave
  logic [31:0]      ctrl_q;
  logic [31:0]      delay_q;
  logic [31:0]      sw_q [NSW];
  logic [31:0]      lin_q;
  logic [31:0]      mask_q;
  logic [FLG_W-1:0] flags_q;
  logic [FLG_W-1:0] flagSet;
  logic [FLG_W-1:0] flagClr;
  logic             ack_q;
  logic             wrDo;
  logic             busOpen;
  logic [NREG-1:0]  enVec;
  logic [NREG-1:0]  liveVec;
  logic [NSW-1:0]   rampVec;
  logic [31:0]      statusWord;
  rpc_state_t       state_q;
  logic [23:0]      loadCnt_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
    return (old & ~m) | (wd & m);
  endfunction : merge

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction : hit

  assign busOpen = (state_q != ST_LOAD);
  assign wrDo    = ack_q & avs_write;

  // Answer one cycle after the request; load phase keeps the bus stalled
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= ~ack_q & busOpen & (avs_read | avs_write);

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~(~ack_q & busOpen & (avs_read | avs_write));

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (~ack_q & avs_read)
    begin
      unique case (avs_address)
        OFF_CTRL:   avs_readdata <= ctrl_q;
        OFF_DELAY:  avs_readdata <= delay_q;
        OFF_SW0:    avs_readdata <= sw_q[0];
        OFF_SW1:    avs_readdata <= sw_q[1];
        OFF_LIN:    avs_readdata <= lin_q;
        OFF_MASK:   avs_readdata <= mask_q;
        OFF_FLAGS:  avs_readdata <= {{(32-FLG_W){1'b0}}, flags_q};
        OFF_STATUS: avs_readdata <= statusWord;
        default:    avs_readdata <= 32'h0000_0000;
      endcase
    end

  assign statusWord = {19'h0_0000, ana.extClkOk, state_q == ST_ACTV,
                       drive.clkSelExt, rampVec, enVec, liveVec};

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_q  <= CTRL_RST;
      delay_q <= DELAY_RST;
      lin_q   <= LIN_RST;
      mask_q  <= MASK_RST;
    end
    else if (wrDo)
    begin
      if (hit(avs_address, OFF_CTRL))
        ctrl_q <= merge(ctrl_q, avs_writedata, avs_byteenable, CTRL_WMSK);
      if (hit(avs_address, OFF_DELAY))
        delay_q <= merge(delay_q, avs_writedata, avs_byteenable, '1);
      if (hit(avs_address, OFF_LIN))
        lin_q <= merge(lin_q, avs_writedata, avs_byteenable, LIN_WMSK);
      if (hit(avs_address, OFF_MASK))
        mask_q <= merge(mask_q, avs_writedata, avs_byteenable, MASK_WMSK);
    end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      sw_q[0] <= SW_RST;
      sw_q[1] <= SW_RST;
    end
    else if (wrDo)
    begin
      if (hit(avs_address, OFF_SW0))
        sw_q[0] <= merge(sw_q[0], avs_writedata, avs_byteenable, SW_WMSK);
      if (hit(avs_address, OFF_SW1))
        sw_q[1] <= merge(sw_q[1], avs_writedata, avs_byteenable, SW_WMSK);
    end

  // Write-one clear; a hardware set in the same cycle wins
  assign flagClr = (wrDo && hit(avs_address, OFF_FLAGS)) ?
                   {avs_writedata[FLG_SYNC] & avs_byteenable[1],
                    avs_writedata[FLG_SYNC-1:0] &
                    {FLG_SYNC{avs_byteenable[0]}}} : '0;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      flags_q <= '0;
    else
      flags_q <= (flags_q & ~flagClr) | flagSet;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      irq_out_low <= 1'b1;
    else
      irq_out_low <= ~|(flags_q & ~{ctrl_q[CTRL_SMASK], 8'h00});

  ////////////////////////////////////////////////////////////////////////
  // Operating state
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      state_q   <= ST_LOAD;
      loadCnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_LOAD:
        begin
          loadCnt_q <= loadCnt_q + 24'h00_0001;
          if (loadCnt_q == 24'(LOAD_CYC - 1))
            state_q <= ST_STBY;
        end
        ST_STBY: if (|enVec) state_q <= ST_ACTV;
        ST_ACTV: if (~|enVec) state_q <= ST_STBY;
      endcase
    end

  ////////////////////////////////////////////////////////////////////////
  // Clock selection and sync events
  logic pllOn;
  logic clkExpectMiss;

  assign pllOn = ctrl_q[CTRL_PLL];
  // A missing clock is reported on entering active; at the end of load the sync enable bit is still clear
  assign clkExpectMiss = pllOn & ~ana.extClkOk &
                         ((state_q == ST_LOAD &&
                           loadCnt_q == 24'(LOAD_CYC - 1)) ||
                          (state_q == ST_STBY && |enVec));

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      drive.clkSelExt <= 1'b0;
    else
      drive.clkSelExt <= pllOn & ana.extClkOk;

  assign flagSet[FLG_SYNC] = pllOn & ((ana.extClkOk ^ extLast_q) |
                                      clkExpectMiss);

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      drive.pinPulldownOn <= 1'b0;
    else
      drive.pinPulldownOn <= ctrl_q[CTRL_PD];

  ////////////////////////////////////////////////////////////////////////
  // Per regulator enable, delay, protection and power good
  logic [NREG-1:0] shortEv;
  logic [NREG-1:0] riseEv;
  logic [NREG-1:0] fallEv;
  logic            enQ   [NREG];
  logic            liveQ [NREG];
  logic [NREG-1:0] linTrig;

  function automatic logic [23:0] waitCycles(input logic [3:0] w);
    return 24'(w * DLY_CYC);
  endfunction : waitCycles

  // A new code on a linear regulator restarts its good blanking
  assign linTrig[0] = 1'b0;
  assign linTrig[1] = 1'b0;
  for (genvar l = 0; l < 2; l++)
  begin : g_lin_trig
    assign linTrig[2+l] = wrDo && hit(avs_address, OFF_LIN) &&
      avs_byteenable[l] &&
      avs_writedata[l*LIN_STRIDE +: 5] != lin_q[l*LIN_STRIDE +: 5];
  end

  for (genvar i = 0; i < NREG; i++)
  begin : g_reg
    logic        onBit;
    logic        follow;
    logic        reqOn;
    logic        valid;
    logic        win;
    logic        trip;
    logic        pinOn_q;
    logic        dlyPend_q;
    logic        dlyTgt_q;
    logic [23:0] dlyCnt_q;
    logic        trip_q;
    logic [23:0] shortCnt_q;
    logic [23:0] blank_q;
    logic [3:0]  startW;
    logic [3:0]  stopW;

    assign onBit  = ctrl_q[CTRL_ON + i];
    assign follow = ctrl_q[CTRL_FOLLOW + i];
    assign startW = delay_q[i*DLY_STRIDE +: 4];
    assign stopW  = delay_q[i*DLY_STRIDE + DLY_STOP +: 4];

    // Pin-edge delays; register writes bypass them entirely
    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
      begin
        pinOn_q   <= 1'b0;
        dlyPend_q <= 1'b0;
        dlyTgt_q  <= 1'b0;
        dlyCnt_q  <= '0;
      end
      else if (pinRise)
      begin
        pinOn_q   <= (startW == 4'h0) | pinOn_q;
        dlyPend_q <= (startW != 4'h0);
        dlyTgt_q  <= 1'b1;
        dlyCnt_q  <= waitCycles(startW) - 24'h00_0001;
      end
      else if (pinFall)
      begin
        pinOn_q   <= (stopW != 4'h0) & pinOn_q;
        dlyPend_q <= (stopW != 4'h0);
        dlyTgt_q  <= 1'b0;
        dlyCnt_q  <= waitCycles(stopW) - 24'h00_0001;
      end
      else if (dlyPend_q)
      begin
        if (dlyCnt_q == 24'h00_0000)
        begin
          pinOn_q   <= dlyTgt_q;
          dlyPend_q <= 1'b0;
        end
        else
          dlyCnt_q <= dlyCnt_q - 24'h00_0001;
      end

    assign reqOn = busOpen & onBit &
                   (~follow | pinOn_q);

    // Short or overload: same 1 ms debounce at start-up and in operation
    assign trip = enQ[i] & ana.belowShort[i] &
                  (shortCnt_q == 24'(SHORT_CYC - 1));

    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
        shortCnt_q <= '0;
      else if (enQ[i] & ana.belowShort[i] & ~trip)
        shortCnt_q <= shortCnt_q + 24'h00_0001;
      else
        shortCnt_q <= '0;

    // Trip holds the output off until the request itself drops
    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
        trip_q <= 1'b0;
      else if (trip)
        trip_q <= 1'b1;
      else if (!reqOn)
        trip_q <= 1'b0;

    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
        enQ[i] <= 1'b0;
      else
        enQ[i] <= reqOn & ~trip_q & ~trip;

    assign shortEv[i] = trip;

    assign win   = (i < NSW) ? ctrl_q[CTRL_SWWIN] : ctrl_q[CTRL_LNWIN];
    assign valid = ana.underOk[i] & ~(win & ana.overHigh[i]);

    // Blanking hides the moving reference during a linear code change
    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
        blank_q <= '0;
      else if (linTrig[i])
        blank_q <= 24'(SETTLE_CYC);
      else if (blank_q != 24'h00_0000)
        blank_q <= blank_q - 24'h00_0001;

    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
        liveQ[i] <= 1'b0;
      else if (blank_q == 24'h00_0000)
        liveQ[i] <= valid;

    assign riseEv[i] = (blank_q == 24'h00_0000) & valid & ~liveQ[i] &
                       ~mask_q[i];
    assign fallEv[i] = (blank_q == 24'h00_0000) & ~valid & liveQ[i] &
                       ~mask_q[MASK_FALL + i];
    assign enVec[i]   = enQ[i];
    assign liveVec[i] = liveQ[i];
  end

  assign flagSet[NREG-1:0]            = shortEv;
  assign flagSet[FLG_GOOD +: NREG]    = riseEv | fallEv;
  assign drive.regOn                  = enVec;

  ////////////////////////////////////////////////////////////////////////
  // Switcher soft-start, ramp and frequency mode
  logic [7:0] swCur_q [NSW];

  for (genvar s = 0; s < NSW; s++)
  begin : g_sw
    logic [23:0] tick_q;
    logic [2:0]  rate;
    logic [7:0]  tgt;
    logic        tickDone;

    assign rate     = sw_q[s][SW_RATE +: 3];
    assign tgt      = sw_q[s][7:0];
    // Larger rate field gives a faster ramp
    assign tickDone = tick_q >= 24'(RAMP_CYC << (3'h7 - rate)) - 24'h00_0001;

    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
        drive.softStart[s] <= 1'b0;
      else
        drive.softStart[s] <= enQ[s] & ana.belowShort[s];

    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
      begin
        swCur_q[s] <= 8'h00;
        tick_q     <= '0;
      end
      else if (!enQ[s] || drive.softStart[s])
      begin
        swCur_q[s] <= 8'h00;
        tick_q     <= '0;
      end
      else if (swCur_q[s] == tgt)
        tick_q <= '0;
      else if (tickDone)
      begin
        tick_q     <= '0;
        swCur_q[s] <= (swCur_q[s] < tgt) ? swCur_q[s] + 8'h01 :
                                           swCur_q[s] - 8'h01;
      end
      else
        tick_q <= tick_q + 24'h00_0001;

    assign rampVec[s] = enQ[s] & (swCur_q[s] != tgt);

    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
        drive.fixedFreq[s] <= 1'b0;
      else
        drive.fixedFreq[s] <= ctrl_q[CTRL_FFF + s] | rampVec[s];
  end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      drive.swCode0  <= 8'h00;
      drive.swCode1  <= 8'h00;
      drive.linCode0 <= 5'h00;
      drive.linCode1 <= 5'h00;
    end
    else
    begin
      drive.swCode0  <= swCur_q[0];
      drive.swCode1  <= swCur_q[1];
      drive.linCode0 <= lin_q[4:0];
      drive.linCode1 <= lin_q[LIN_STRIDE +: 5];
    end

endmodule : rpc_regulator_ctrl

/* testbench/rpc_monitor.sv */
// Checker of regulator control port relations
`timescale 1ns/100ps
module rpc_monitor
  import rpc_pkg::*;
#(
  parameter int SHORT_CYC = 16
)(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire rpc_ana_t    anaIn,
  input wire rpc_drive_t  drive,
  input wire logic        irq_out_low
);
  logic [15:0] shadow_q;
  int          shortCnt_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////
  // Control word copy, taken at the commit edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      shadow_q <= 16'h0000;
    else if (avs_write && !avs_waitrequest && avs_address == OFF_CTRL)
    begin
      if (avs_byteenable[0])
        shadow_q[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        shadow_q[15:8] <= avs_writedata[15:8];
    end
  end
  // Counter, as a long repetition would crawl
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      shortCnt_q <= 0;
    else if (drive.regOn[0] && anaIn.belowShort[0])
      shortCnt_q <= shortCnt_q + 1;
    else
      shortCnt_q <= 0;
  end
////////////////////////////////////////////////////////////////////////////
  a_wait_load: assert property
    ($rose(rst_n) |-> avs_waitrequest [*8])
    else $error("bus answered during load");
  a_wait_one: assert property
    (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property
    (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
     |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_off_clear: assert property
    (shadow_q[3:0] == $past(shadow_q[3:0], 2)
     |-> (drive.regOn & ~shadow_q[3:0]) == 4'h0)
    else $error("regulator on with on bit clear");
  a_clk_internal: assert property
    (!shadow_q[8] [*2] |-> !drive.clkSelExt)
    else $error("external clock used while disabled");
  a_clk_external: assert property
    ((shadow_q[8] && anaIn.extClkOk) [*6] |-> drive.clkSelExt)
    else $error("valid external clock not selected");
  a_pull_follow: assert property
    (shadow_q[9] == $past(shadow_q[9]) |-> drive.pinPulldownOn == shadow_q[9])
    else $error("pulldown not per config bit");
  a_short_bound: assert property
    (shortCnt_q < SHORT_CYC + 6)
    else $error("short not tripped in time");
  a_short_irq: assert property
    ($fell(drive.regOn[0]) && shadow_q[0] && !shadow_q[4]
     |-> ##[1:3] !irq_out_low)
    else $error("short trip without interrupt");
endmodule : rpc_monitor

bind rpc_regulator_ctrl rpc_monitor #(.SHORT_CYC(SHORT_CYC)) mon_u (
  .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .anaIn(anaIn), .drive(drive),
  .irq_out_low(irq_out_low)
);

/* testbench/rpc_rail_model.sv */
// Behavioural rails and comparators facing the control block
`timescale 1ns/100ps
module rpc_rail_model
  import rpc_pkg::*;
(
  input wire logic            mclk,
  input wire logic            rst_n,
  input wire logic [NREG-1:0] regOn,
  input wire logic [NREG-1:0] shortReq,
  input wire logic [NREG-1:0] overReq,
  input wire logic            pinLevel,
  input wire logic            extClk,
  output rpc_ana_t            anaOut
);
  logic [NREG-1:0] rise1_q;
  logic [NREG-1:0] rise2_q;
  logic [NREG-1:0] up_q;
////////////////////////////////////////////////////////////////////////////
  // Rail takes three cycles to climb
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise1_q <= 4'h0;
      rise2_q <= 4'h0;
      up_q    <= 4'h0;
    end
    else
    begin
      rise1_q <= regOn;
      rise2_q <= rise1_q;
      up_q    <= rise2_q;
    end
  end
  // Shorted rail never climbs
  assign anaOut = '{belowShort: shortReq | ~up_q,
                    underOk: up_q & ~shortReq,
                    overHigh: overReq,
                    extClkOk: extClk, enablePin: pinLevel};
endmodule : rpc_rail_model

/* testbench/rpc_regulator_ctrl_tb.sv */
// Testbench for regulator control
`timescale 1ns/100ps
module rpc_regulator_ctrl_tb
  import rpc_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  busAddr = 5'h00;
  logic        busRead = 1'b0;
  logic        busWrite = 1'b0;
  logic [31:0] busWdata = 32'h0;
  logic [31:0] busRdata;
  logic        busWait;
  logic [3:0]  shortReq = 4'h0;
  logic [3:0]  busBe = 4'hF;
  logic [3:0]  overReq = 4'h0;
  logic        pinLevel = 1'b0;
  logic        extClk = 1'b0;
  logic        irqLow;
  rpc_ana_t    ana;
  rpc_drive_t  drv;
  logic [31:0] q;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
////////////////////////////////////////////////////////////////////////////
  rpc_regulator_ctrl #(.LOAD_CYC(20), .SHORT_CYC(16), .DLY_CYC(8),
    .SETTLE_CYC(10), .RAMP_CYC(2)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .avs_address(busAddr), .avs_read(busRead), .avs_write(busWrite),
    .avs_writedata(busWdata), .avs_byteenable(busBe),
    .avs_readdata(busRdata), .avs_waitrequest(busWait), .anaIn(ana),
    .drive(drv), .irq_out_low(irqLow));
  rpc_rail_model rail_u (.mclk(mclk), .rst_n(rst_n), .regOn(drv.regOn),
    .shortReq(shortReq), .overReq(overReq), .pinLevel(pinLevel),
    .extClk(extClk), .anaOut(ana));
////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 mclk = ~mclk;
  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      fail_count++;
      close_out();
    end
  end
  task close_out;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low at an edge
  task xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    busAddr <= a;
    busWdata <= d;
    busWrite <= w;
    busRead <= !w;
    do
    begin
      @(posedge mclk);
      n++;
    end while (busWait !== 1'b0 && n < 200);
    if (busWait !== 1'b0)
      fail_count++;
    q = busRdata;
    busRead <= 1'b0;
    busWrite <= 1'b0;
    @(posedge mclk);
  endtask : xfer
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(5);
    rst_n <= 1'b1;
    tick(20);
    for (int a = 0; a < 28; a += 4)
    begin
      xfer(0, 5'(a), 32'h0);
      chk(q, 32'h0);
    end
    xfer(1, 5'h03, 32'hFFFF);
    xfer(0, 5'h03, 32'h0);
    chk(q, 32'h0);
    xfer(0, OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    xfer(1, OFF_CTRL, 32'h3);
    tick(2);
    chk(32'(drv.regOn), 32'h3);
    tick(12);
    xfer(0, OFF_STATUS, 32'h0);
    chk(q & 32'hFF, 32'h33);
    xfer(0, OFF_FLAGS, 32'h0);
    chk(q, 32'h30);
    chk(32'(irqLow), 32'h0);
    xfer(1, OFF_FLAGS, 32'h1FF);
    xfer(0, OFF_FLAGS, 32'h0);
    chk(q, 32'h0);
    chk(32'(irqLow), 32'h1);
    xfer(1, OFF_MASK, 32'h10);
    xfer(1, OFF_CTRL, 32'h0);
    tick(15);
    xfer(0, OFF_FLAGS, 32'h0);
    chk(q, 32'h20);
    xfer(1, OFF_FLAGS, 32'h1FF);
    xfer(1, OFF_MASK, 32'hFF);
    xfer(1, OFF_DELAY, 32'h0012_0000);
    xfer(1, OFF_CTRL, 32'h44);
    pinLevel <= 1'b1;
    tick(10);
    chk(32'(drv.regOn), 32'h0);
    tick(15);
    chk(32'(drv.regOn), 32'h4);
    pinLevel <= 1'b0;
    tick(5);
    chk(32'(drv.regOn), 32'h4);
    tick(12);
    chk(32'(drv.regOn), 32'h0);
    shortReq <= 4'h9;
    xfer(1, OFF_CTRL, 32'h9);
    tick(30);
    chk(32'(drv.regOn), 32'h0);
    xfer(0, OFF_FLAGS, 32'h0);
    chk(q, 32'h9);
    chk(32'(irqLow), 32'h0);
    xfer(1, OFF_FLAGS, 32'h1FF);
    tick(2);
    chk(32'(irqLow), 32'h1);
    xfer(1, OFF_CTRL, 32'h0);
    shortReq <= 4'h0;
    extClk <= 1'b1;
    tick(6);
    chk(32'(drv.clkSelExt), 32'h0);
    xfer(0, OFF_FLAGS, 32'h0);
    chk(q, 32'h0);
    xfer(1, OFF_CTRL, 32'h100);
    tick(6);
    chk(32'(drv.clkSelExt), 32'h1);
    extClk <= 1'b0;
    tick(6);
    chk(32'(drv.clkSelExt), 32'h0);
    xfer(0, OFF_FLAGS, 32'h0);
    chk(q, 32'h100);
    busBe <= 4'h1;
    xfer(1, OFF_FLAGS, 32'h1FF);
    busBe <= 4'hF;
    xfer(0, OFF_FLAGS, 32'h0);
    chk(q, 32'h100);
    xfer(1, OFF_FLAGS, 32'h1FF);
    xfer(1, OFF_CTRL, 32'h200);
    tick(2);
    chk(32'(drv.pinPulldownOn), 32'h1);
    xfer(1, OFF_SW0, 32'h704);
    xfer(1, OFF_CTRL, 32'h1);
    tick(5);
    chk(32'(drv.fixedFreq[0]), 32'h1);
    chk(32'(drv.softStart[0]), 32'h1);
    tick(30);
    chk(32'(drv.swCode0), 32'h4);
    chk(32'(drv.fixedFreq[0]), 32'h0);
    chk(32'(drv.softStart[0]), 32'h0);
    overReq <= 4'h1;
    tick(6);
    xfer(0, OFF_STATUS, 32'h0);
    chk(q & 32'hF, 32'h1);
    xfer(1, OFF_CTRL, 32'h1C05);
    tick(12);
    chk(32'(drv.fixedFreq[0]), 32'h1);
    xfer(0, OFF_STATUS, 32'h0);
    chk(q & 32'hF, 32'h4);
    xfer(1, OFF_LIN, 32'h3);
    overReq <= 4'h5;
    tick(2);
    xfer(0, OFF_STATUS, 32'h0);
    chk(q & 32'hF, 32'h4);
    tick(10);
    xfer(0, OFF_STATUS, 32'h0);
    chk(q & 32'hF, 32'h0);
    chk(32'(drv.linCode0), 32'h3);
    close_out();
  end
endmodule : rpc_regulator_ctrl_tb
